// file: pmc_power_mgmt.sv
/*
  Power-management capability register bank: identity word, capability
  header and control/status word, reached by configuration reads and writes.
  Assumes configuration strobes are one-cycle pulses synchronous to core_clk,
  and that wake events and power resume arrive as one-cycle pulses.
*/
`timescale 1ns/1ps
module pmc_power_mgmt
  import pmc_pkg::*;
#(
  // Arbitrary identification values, not those of any real part.
  parameter logic [15:0] DEVICE_CODE = 16'h00d1,
  parameter logic [15:0] MAKER_CODE  = 16'h00a1
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Configuration access
  input  wire logic [7:0]  cfg_addr,
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_ack,
  // Wake logic
  input  wire logic        wake_event,
  input  wire logic        power_resume,
  input  wire logic [1:0]  command_register_wake,
  output logic             magic_wake_enable,
  output pmc_pwr_t         power_state,
  // Open-drain wake pin
  input  wire logic        pme_n_i,
  output logic             pme_n_o,
  output logic             pme_n_oe_n
);

  // ==========================================================================
  // Read value builders
  // ==========================================================================
  function automatic logic [31:0] cap_word();
    cap_word = {PMC_WAKE_SUPPORT, PMC_DEEP_DOZE, PMC_LIGHT_DOZE, PMC_STANDBY_CUR,
                PMC_SPECIAL_INIT, PMC_CAP_RSVD20, PMC_NEEDS_CLK, PMC_SPEC_REV,
                PMC_NEXT_LINK, PMC_CAP_CODE};
  endfunction : cap_word

  function automatic logic [31:0] ctrl_word(input logic flag, input logic [3:0] data_selector,
                                            input logic en, input logic [1:0] ps);
    ctrl_word = {PMC_UPPER_ZERO, flag, PMC_SCALE_VALUE, data_selector, en, PMC_CTRL_RSVD, ps};
  endfunction : ctrl_word

  // ==========================================================================
  // Control state
  // ==========================================================================
  logic       flag_reg;
  logic       flag_next;
  logic       en_reg;
  logic       en_next;
  logic [3:0] data_selector_reg;
  logic [3:0] data_selector_next;
  pmc_pwr_t   pstate_reg;
  pmc_pwr_t   pstate_next;
  logic       ctrl_wr;
  logic       wr_low;
  logic       wr_high;

  assign ctrl_wr = cfg_wr && (cfg_addr == PMC_OFS_CTRL_STAT);
  assign wr_low  = ctrl_wr && cfg_be[PMC_BE_LOW];
  assign wr_high = ctrl_wr && cfg_be[PMC_BE_HIGH];

  always_comb
  begin
    // event sets flag, set wins over clear
    // only a written one clears the flag
    flag_next = (flag_reg & ~(wr_high & cfg_wdata[PMC_FLAG_BIT])) | wake_event;
    en_next   = wr_high ? cfg_wdata[PMC_EN_BIT] : en_reg;
    data_selector_next = wr_high ? cfg_wdata[PMC_DATA_SELECTOR_MSB:PMC_DATA_SELECTOR_LSB] : data_selector_reg;
    pstate_next = pstate_reg;
    if (power_resume)
    begin
      pstate_next = PMC_D0;
    end
    else if (wr_low)
    begin
      pstate_next = pmc_pwr_t'(cfg_wdata[PMC_PSTATE_MSB:PMC_PSTATE_LSB]);
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flag_reg   <= PMC_FLAG_RESET;
      en_reg     <= PMC_EN_RESET;
      data_selector_reg   <= PMC_DATA_SELECTOR_RESET;
      pstate_reg <= PMC_D0;
    end
    else
    begin
      flag_reg   <= flag_next;
      en_reg     <= en_next;
      data_selector_reg   <= data_selector_next;
      pstate_reg <= pstate_next;
    end
  end

  assign power_state = pstate_reg;

  // magic wake enabled by the enable bit or by both command bits set
  assign magic_wake_enable = en_reg | (&command_register_wake);

  // ==========================================================================
  // Read path
  // ==========================================================================
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        ack_reg;
  logic        ack_next;

  always_comb
  begin
    ack_next   = cfg_rd | cfg_wr;
    rdata_next = rdata_reg;
    if (cfg_rd)
    begin
      unique case (cfg_addr)
        PMC_OFS_ID_WORD:   rdata_next = {DEVICE_CODE, MAKER_CODE};
        PMC_OFS_CAP_HDR:   rdata_next = cap_word();
        PMC_OFS_CTRL_STAT: rdata_next = ctrl_word(flag_reg, data_selector_reg, en_reg, pstate_reg);
        default:           rdata_next = PMC_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_reg <= PMC_UNMAPPED;
      ack_reg   <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
    end
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_ack   = ack_reg;

  // ==========================================================================
  // Wake pin
  // ==========================================================================
  pmc_wake_pin u_wake_pin (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .flag       (flag_reg),
    .enable     (en_reg),
    .pme_n_o    (pme_n_o),
    .pme_n_oe_n (pme_n_oe_n)
  );

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_flag_set;
    @(posedge core_clk) disable iff (!nrst)
      wake_event |=> flag_reg ##1 (flag_reg || $past(wr_high));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("wake event did not set flag");

  property p_flag_clear;
    @(posedge core_clk) disable iff (!nrst)
      (wr_high && cfg_wdata[PMC_FLAG_BIT] && !wake_event) |=> !flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("write one did not clear flag");

  property p_flag_keep;
    @(posedge core_clk) disable iff (!nrst)
      (flag_reg && !(wr_high && cfg_wdata[PMC_FLAG_BIT])) |=> flag_reg;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag lost without write one");

  property p_pin_gated;
    @(posedge core_clk) disable iff (!nrst)
      !pme_n_oe_n |-> ($past(en_reg) && $past(flag_reg));
  endproperty
  a_pin_gated: assert property (p_pin_gated) else $error("wake pin driven while disabled");

  property p_pin_follows;
    @(posedge core_clk) disable iff (!nrst)
      (flag_reg && en_reg) |=> !pme_n_oe_n;
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("enabled wake not driven");

  // The resolved pin must show low whenever this block drives it.
  property p_pin_level;
    @(posedge core_clk) disable iff (!nrst)
      !pme_n_oe_n |-> !pme_n_i;
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("wake pin not low while driven");

  property p_magic;
    @(posedge core_clk) disable iff (!nrst)
      (&command_register_wake) |-> magic_wake_enable;
  endproperty
  a_magic: assert property (p_magic) else $error("magic wake not forced on");

  property p_pstate_write;
    @(posedge core_clk) disable iff (!nrst)
      (wr_low && !power_resume) |=>
        (power_state == pmc_pwr_t'($past(cfg_wdata[PMC_PSTATE_MSB:PMC_PSTATE_LSB])));
  endproperty
  a_pstate_write: assert property (p_pstate_write) else $error("power state not written");

  property p_resume;
    @(posedge core_clk) disable iff (!nrst)
      power_resume |=> (power_state == PMC_D0);
  endproperty
  a_resume: assert property (p_resume) else $error("resume did not return to D0");

  property p_data_selector;
    @(posedge core_clk) disable iff (!nrst)
      wr_high |=> ##1 (cfg_rd && cfg_addr == PMC_OFS_CTRL_STAT && !wr_high) |=>
        (cfg_rdata[PMC_DATA_SELECTOR_MSB:PMC_DATA_SELECTOR_LSB] == $past(data_selector_reg));
  endproperty
  a_data_selector: assert property (p_data_selector) else $error("selector readback wrong");

  property p_scale_zero;
    @(posedge core_clk) disable iff (!nrst)
      (cfg_rd && cfg_addr == PMC_OFS_CTRL_STAT) |=>
        (cfg_ack && cfg_rdata[PMC_SCALE_MSB:PMC_SCALE_LSB] == PMC_SCALE_VALUE);
  endproperty
  a_scale_zero: assert property (p_scale_zero) else $error("scale field not zero");

  property p_cap_read;
    @(posedge core_clk) disable iff (!nrst)
      (cfg_rd && cfg_addr == PMC_OFS_CAP_HDR) |=> (cfg_ack && cfg_rdata == 32'hfe82_0001);
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("capability header wrong");

  property p_id_read;
    @(posedge core_clk) disable iff (!nrst)
      (cfg_rd && cfg_addr == PMC_OFS_ID_WORD) |=>
        (cfg_rdata[31:PMC_ID_DEV_LSB] == DEVICE_CODE && cfg_rdata[15:0] == MAKER_CODE);
  endproperty
  a_id_read: assert property (p_id_read) else $error("identity word wrong");

  property p_reset_defaults;
    @(posedge core_clk) disable iff (!nrst)
      $rose(nrst) |-> (!en_reg && data_selector_reg == PMC_DATA_SELECTOR_RESET && power_state == PMC_D0);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong");

endmodule : pmc_power_mgmt

// file: pmc_pkg.sv
/*
  Constants and types for the power-management capability register bank:
  register offsets, field positions, fixed read-only values and power states.
  Assumes configuration addresses are byte addresses of aligned 32-bit words.
*/
package pmc_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] PMC_OFS_ID_WORD   = 8'h80;
  localparam logic [7:0] PMC_OFS_CAP_HDR   = 8'hc0;
  localparam logic [7:0] PMC_OFS_CTRL_STAT = 8'hc4;

  // ==========================================================================
  // Identity word layout
  // ==========================================================================
  localparam int PMC_ID_DEV_LSB   = 16;
  localparam int PMC_ID_MAKER_LSB = 0;

  // ==========================================================================
  // Capability header fields
  // ==========================================================================
  localparam logic [7:0] PMC_CAP_CODE      = 8'h01;
  localparam logic [7:0] PMC_NEXT_LINK     = 8'h00;
  localparam logic [2:0] PMC_SPEC_REV      = 3'h2;
  localparam logic       PMC_NEEDS_CLK     = 1'b0;
  localparam logic       PMC_SPECIAL_INIT  = 1'b0;
  localparam logic [2:0] PMC_STANDBY_CUR   = 3'h2;
  localparam logic       PMC_LIGHT_DOZE    = 1'b1;
  localparam logic       PMC_DEEP_DOZE     = 1'b1;
  localparam logic [4:0] PMC_WAKE_SUPPORT  = 5'h1f;
  localparam logic       PMC_CAP_RSVD20    = 1'b0;

  // ==========================================================================
  // Control and status word layout
  // ==========================================================================
  localparam int PMC_FLAG_BIT     = 15;
  localparam int PMC_SCALE_MSB    = 14;
  localparam int PMC_SCALE_LSB    = 13;
  localparam int PMC_DATA_SELECTOR_MSB     = 12;
  localparam int PMC_DATA_SELECTOR_LSB     = 9;
  localparam int PMC_EN_BIT       = 8;
  localparam int PMC_PSTATE_MSB   = 1;
  localparam int PMC_PSTATE_LSB   = 0;
  localparam int PMC_BE_LOW       = 0;
  localparam int PMC_BE_HIGH      = 1;

  localparam logic [1:0] PMC_SCALE_VALUE = 2'h0;
  localparam logic [3:0] PMC_DATA_SELECTOR_RESET  = 4'h0;
  localparam logic       PMC_EN_RESET    = 1'b0;
  localparam logic       PMC_FLAG_RESET  = 1'b0;
  localparam logic [5:0] PMC_CTRL_RSVD   = 6'h00;
  localparam logic [15:0] PMC_UPPER_ZERO = 16'h0000;
  localparam logic [31:0] PMC_UNMAPPED   = 32'h0000_0000;

  // ==========================================================================
  // Power states
  // ==========================================================================
  typedef enum logic [1:0] {
    PMC_D0    = 2'b00,
    PMC_D1    = 2'b01,
    PMC_D2    = 2'b10,
    PMC_D3HOT = 2'b11
  } pmc_pwr_t;

endpackage : pmc_pkg

// file: pmc_wake_pin.sv
/*
  Drives the open-drain wake request pin from the wake flag and its enable.
  Assumes the pin is resolved outside; the enable output is low while driving.
*/
`timescale 1ns/1ps
module pmc_wake_pin
  import pmc_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Wake state
  input  wire logic flag,
  input  wire logic enable,
  // Open-drain wake pin
  output logic      pme_n_o,
  output logic      pme_n_oe_n
);

  logic drive_reg;
  logic drive_next;

  // ==========================================================================
  // Pin drive
  // ==========================================================================
  always_comb
  begin
    drive_next = flag & enable;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      drive_reg <= 1'b0;
    end
    else
    begin
      drive_reg <= drive_next;
    end
  end

  assign pme_n_o    = 1'b0;
  assign pme_n_oe_n = ~drive_reg;

endmodule : pmc_wake_pin

// file: pmc_host_model.sv
/*
  Host-side model: makes configuration reads and writes and resolves the
  pulled-up wake pin. Assumes one-cycle strobes with ack one cycle later.
*/
`timescale 1ns/1ps
module pmc_host_model
  import pmc_pkg::*;
(
  // Clock
  input  wire logic        core_clk,
  // Configuration access
  output logic [7:0]       cfg_addr,
  output logic             cfg_rd,
  output logic             cfg_wr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_ack,
  // Wake pin
  input  wire logic        pme_n_o,
  input  wire logic        pme_n_oe_n,
  output logic             pme_n
);
  // A released pin is pulled high.
  assign pme_n = pme_n_oe_n ? 1'b1 : pme_n_o;

  initial
  begin
    cfg_addr = 8'h00;
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  // Idle address and data lines show the inverse so stale values are never mistaken.
  task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] q, output logic ok);
    @(posedge core_clk);
    #1;
    cfg_rd = !wr;
    cfg_wr = wr;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(posedge core_clk);
    #1;
    ok = cfg_ack;
    q = cfg_rdata;
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = ~a;
    cfg_wdata = ~d;
  endtask : access
endmodule : pmc_host_model

// file: tb_top.sv
/*
  Self-checking bench for the power-management register bank.
  Assumes the host model drives all configuration traffic.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin failures++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top
  import pmc_pkg::*;
;
  // Arbitrary identification values.
  localparam logic [15:0] DEV = 16'h3c5a;
  localparam logic [15:0] MAK = 16'h7e11;
  localparam logic [31:0] CAP = {5'h1f, 2'b11, 3'h2, 3'h0, 3'h2, 8'h00, 8'h01};
  logic        core_clk, nrst, wake_event, power_resume, ok, magic, pme_n;
  logic        pme_n_o, pme_n_oe_n, cfg_rd, cfg_wr, cfg_ack;
  logic [1:0]  cmd;
  logic [3:0]  cfg_be, ds;
  logic [7:0]  cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, q, seed;
  pmc_pwr_t    power_state;
  int          failures, compares, cycles;

  pmc_power_mgmt #(.DEVICE_CODE(DEV), .MAKER_CODE(MAK)) u_dut (.core_clk(core_clk),
    .nrst(nrst), .cfg_addr(cfg_addr), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .wake_event(wake_event), .power_resume(power_resume), .command_register_wake(cmd),
    .magic_wake_enable(magic), .power_state(power_state), .pme_n_i(pme_n),
    .pme_n_o(pme_n_o), .pme_n_oe_n(pme_n_oe_n));
  pmc_host_model u_host (.core_clk(core_clk), .cfg_addr(cfg_addr), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .pme_n_o(pme_n_o), .pme_n_oe_n(pme_n_oe_n), .pme_n(pme_n));

  function automatic logic [31:0] ctl(logic f, logic [3:0] d, logic e, logic [1:0] p);
    return {16'h0000, f, 2'b00, d, e, 6'h00, p};
  endfunction : ctl

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    u_host.access(1'b0, a, 4'hf, $urandom, d, ok);
    `CHK("read ack", 1'b1, ok)
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    u_host.access(1'b1, a, be, d, q, ok);
    `CHK("write ack", 1'b1, ok)
  endtask : wr

  task automatic pulse(input logic res);
    @(posedge core_clk);
    #1;
    if (res) power_resume = 1'b1;
    else wake_event = 1'b1;
    @(posedge core_clk);
    #1;
    power_resume = 1'b0;
    wake_event = 1'b0;
  endtask : pulse

  task automatic pin(input logic e);
    `CHK("pin enable", e, pme_n_oe_n)
    `CHK("pin level", e, pme_n)
  endtask : pin

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      wrap_up();
    end
  end

  initial
  begin
    nrst = 1'b0;
    wake_event = 1'b0;
    power_resume = 1'b0;
    cmd = 2'h0;
    seed = $urandom(81);
    repeat (16) @(posedge core_clk);
    #1 nrst = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h80 + 8'(i * 64), 4'hf, 32'hffff_ffff);
      wr(8'h84 + 8'(4 * $urandom_range(0, 14)), 4'hf, 32'hffff_ffff);
    end
    rd(8'h80, q); `CHK("identity", {DEV, MAK}, q)
    rd(8'hc0, q); `CHK("cap header", CAP, q)
    rd(8'hc4, q); `CHK("ctl reset", 32'h0, q)
    rd(8'h84 + 8'(4 * $urandom_range(0, 14)), q); `CHK("unmapped", 32'h0, q)
    $display("test read_only done");
    for (int p = 0; p < 4; p++)
    begin
      ds = 4'($urandom);
      wr(8'hc4, 4'h3, {16'hffff, 3'b011, ds, p[0], 6'h3f, 2'(p)});
      rd(8'hc4, q); `CHK("ctl word", ctl(0, ds, p[0], 2'(p)), q)
      `CHK("power state", 2'(p), power_state)
    end
    wr(8'hc4, 4'h0, 32'h0000_0000);
    rd(8'hc4, q); `CHK("no lanes", ctl(0, ds, 1'b1, 2'h3), q)
    $display("test fields done");
    for (int i = 0; i < 8; i++)
    begin
      cmd = 2'(i);
      wr(8'hc4, 4'h2, {23'h0, i[2], 8'h00});
      `CHK("magic enable", i[2] | (&cmd), magic)
    end
    $display("test magic done");
    wr(8'hc4, 4'h3, ctl(0, 0, 0, 0));
    pulse(1'b0);
    repeat (3) @(posedge core_clk);
    pin(1'b1);
    rd(8'hc4, q); `CHK("flag no enable", ctl(1, 0, 0, 0), q)
    wr(8'hc4, 4'h2, ctl(0, 0, 0, 0));
    rd(8'hc4, q); `CHK("flag kept", ctl(1, 0, 0, 0), q)
    wr(8'hc4, 4'h2, ctl(1, 0, 1, 0));
    rd(8'hc4, q); `CHK("flag cleared", ctl(0, 0, 1, 0), q)
    pulse(1'b0);
    pin(1'b1);
    @(posedge core_clk);
    #1 pin(1'b0);
    wr(8'hc4, 4'h2, ctl(1, 0, 1, 0));
    @(posedge core_clk);
    #1 pin(1'b1);
    pulse(1'b0);
    @(posedge core_clk);
    #1 pin(1'b0);
    wr(8'hc4, 4'h2, ctl(0, 0, 0, 0));
    @(posedge core_clk);
    #1 pin(1'b1);
    rd(8'hc4, q); `CHK("flag stays", ctl(1, 0, 0, 0), q)
    $display("test wake done");
    wr(8'hc4, 4'h1, ctl(0, 0, 0, 3));
    pulse(1'b1);
    `CHK("resume state", PMC_D0, power_state)
    rd(8'hc4, q); `CHK("resume word", 2'h0, q[1:0])
    $display("test resume done");
    wr(8'hc4, 4'h3, ctl(1, 5, 1, 2));
    #3 nrst = 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK("reset state", PMC_D0, power_state)
    #1 nrst = 1'b1;
    rd(8'hc4, q); `CHK("ctl after reset", 32'h0, q)
    $display("test reset done");
    wrap_up();
  end
endmodule : tb_top
